// [src/ges_event_status.sv]
`default_nettype none
// =====================================================================
// Event status and interrupt logic of the bus port core.
// Summary of operation
// - Lost output byte sets error flag.
// - Error flag clears on reset, first-status read.
// - Data-out flag sets entering talk with generate.
// - Data-out clears on read, leaving, byte write.
// - DMA-out enabled talker requests DMA unless data-out interrupt enabled.
// - Data-in flag sets on continuous-listen accept.
// - Data-in clears: reset, read, finish holdoff, input read.
// - DMA-in enabled listener requests DMA unless data-in interrupt enabled.
// - Enabled event raises interrupt request.
// - Second status flags ignore mask bits.
// - Changes during second status read wait.
// - Bit seven is OR of enabled flags.
// - Controller sets service-request flag on request.
// - Change flags clear on reset and read.
// - Lockout bit shows lock, never interrupts.
// - Remote bit shows remote state.
// - Command-out flag: set on generate, clear leaving.
// - Lockout or remote change sets change flag.
// - Role change sets flag unless only-mode.
// - First status pair at offset one-thirteen.
module ges_event_status (
   input wire logic clk,
   input wire logic rst,
   input wire logic [8:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   input wire ges_pkg::ges_core_t core,
   output logic irq,
   output logic dma_req
);
   // ==================================================================
   // Address decode.
   function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
      hit = (a == o);
   endfunction

   logic rd_a;
   logic rd_b;
   logic wr_a;
   logic wr_b;
   logic out_byte_wr;
   assign rd_a = host_rd & hit(host_addr, ges_pkg::OFS_STAT_A);
   assign rd_b = host_rd & hit(host_addr, ges_pkg::OFS_STAT_B);
   assign wr_a = host_wr & hit(host_addr, ges_pkg::OFS_STAT_A);
   assign wr_b = host_wr & hit(host_addr, ges_pkg::OFS_STAT_B);
   assign out_byte_wr = host_wr & hit(host_addr, ges_pkg::OFS_OUT_BYTE);

   // ==================================================================
   // Enable registers.
   logic [7:0] en_a_q;
   logic [7:0] en_a_d;
   logic [6:0] en_b_q;
   logic [6:0] en_b_d;
   // A write lands at once so the interrupt bit sees it the same edge.
   always_comb begin
      en_a_d = wr_a ? host_wdata : en_a_q;
      en_b_d = wr_b ? host_wdata[6:0] : en_b_q;
   end
   // Enable registers hold their value between writes.
   always_ff @(posedge clk) begin
      if (rst) begin
         en_a_q <= ges_pkg::RST_BYTE;
         en_b_q <= 7'h00;
      end else begin
         en_a_q <= en_a_d;
         en_b_q <= en_b_d;
      end
   end

   // ==================================================================
   // Lockout and remote levels, held still during a second status read.
   logic lok_q;
   logic rem_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         lok_q <= 1'b0;
         rem_q <= 1'b0;
      end else if (!rd_b) begin
         lok_q <= core.rl_local_lock | core.rl_remote_lock;
         rem_q <= core.rl_remote | core.rl_remote_lock;
      end
   end

   // ==================================================================
   // Watched conditions and their edges.
   logic [ges_pkg::NWATCH-1:0] watch;
   logic [ges_pkg::NWATCH-1:0] rise;
   logic [ges_pkg::NWATCH-1:0] chg;
   logic srq_seen;
   assign srq_seen = core.bus_ctrl_owner_flag & core.srq;
   // Condition levels whose edges set flags.
   always_comb begin
      watch = ges_pkg::RST_WATCH;
      watch[ges_pkg::WA_DO] = core.speaker_active & core.src_generate;
      watch[ges_pkg::WA_DI] = core.listener_active & core.accept_data &
                              core.cont_listen;
      watch[ges_pkg::WA_CO] = core.ctrl_active & core.src_generate;
      watch[ges_pkg::WA_SRQ_A] = srq_seen & ~(core.rqs & core.dav);
      watch[ges_pkg::WA_SRQ_B] = srq_seen & core.rqs & core.dav;
      watch[ges_pkg::WA_LOK] = lok_q;
      watch[ges_pkg::WA_REM] = rem_q;
      watch[ges_pkg::WA_ADDR +: 4] = {core.bus_ctrl_owner_flag,
                                      core.listener_on_flag,
                                      core.speaker_on_flag,
                                      core.minor_addr_flag};
   end

   ges_edge u_edge (
      .clk(clk),
      .rst(rst),
      .level(watch),
      .rise(rise),
      .chg(chg)
   );

   // ==================================================================
   // Set, clear and read-clear terms of each sticky flag.
   logic [ges_pkg::NFLAG-1:0] set_v;
   logic [ges_pkg::NFLAG-1:0] clr_v;
   logic [ges_pkg::NFLAG-1:0] rdclr_v;
   logic [ges_pkg::NFLAG-1:0] flags_d;
   logic [ges_pkg::NFLAG-1:0] flags_q;
   always_comb begin
      set_v = ges_pkg::RST_FLAGS;
      clr_v = ges_pkg::RST_FLAGS;
      // Output byte lost to no listener or written while idle.
      set_v[ges_pkg::FL_ERR] = core.no_listener_send |
         (out_byte_wr & (core.src_idle | core.src_delay_to_idle));
      // Ready for another byte when talking and generating.
      set_v[ges_pkg::FL_DO] = rise[ges_pkg::WA_DO];
      clr_v[ges_pkg::FL_DO] = ~watch[ges_pkg::WA_DO] | out_byte_wr;
      // A byte accepted in continuous listen.
      set_v[ges_pkg::FL_DI] = rise[ges_pkg::WA_DI];
      clr_v[ges_pkg::FL_DI] = (core.finish_hs & core.holdoff) |
                              core.in_byte_read;
      // Service request while owning the controller role.
      set_v[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG] = rise[ges_pkg::WA_SRQ_A] |
                                rise[ges_pkg::WA_SRQ_B];
      // Command register empty while controller generates.
      set_v[ges_pkg::FL_CO] = rise[ges_pkg::WA_CO];
      clr_v[ges_pkg::FL_CO] = ~watch[ges_pkg::WA_CO];
      // Lockout and remote changes.
      set_v[ges_pkg::FL_LOCKOUT_CHANGE_FLAG] = chg[ges_pkg::WA_LOK];
      set_v[ges_pkg::FL_FAR_CONTROL_CHANGE_FLAG] = chg[ges_pkg::WA_REM];
      // Role changes count only outside the only-modes.
      set_v[ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG] = (|chg[ges_pkg::WA_ADDR +: 4]) &
         ~(core.listen_only | core.talk_only);
   end

   // Each read clears the flags of its own register.
   always_comb begin
      rdclr_v = ges_pkg::RST_FLAGS;
      rdclr_v[ges_pkg::FL_ERR:ges_pkg::FL_DI] = {3{rd_a}};
      rdclr_v[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG:ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG] = {5{rd_b}};
   end

   // Flags move on their conditions whatever the masks hold.
   genvar gi;
   generate
      for (gi = 0; gi < ges_pkg::NFLAG; gi++) begin : g_flag
         ges_flag u_flag (
            .clk(clk),
            .rst(rst),
            .set_ev(set_v[gi]),
            .clr_ev(clr_v[gi]),
            .rd_clr(rdclr_v[gi]),
            .flag_d(flags_d[gi]),
            .flag_q(flags_q[gi])
         );
      end
   endgenerate

   // ==================================================================
   // Per-flag enables in flag-vector order.
   function automatic logic [ges_pkg::NFLAG-1:0] flag_en(
      input logic [7:0] ea, input logic [6:0] eb);
      flag_en = {eb[ges_pkg::EB_SVC_REQUEST_SEEN_FLAG], eb[ges_pkg::EB_CO],
                 eb[ges_pkg::EB_LOCKOUT_CHANGE_FLAG], eb[ges_pkg::EB_FAR_CONTROL_CHANGE_FLAG],
                 eb[ges_pkg::EB_ADDR_ROLE_CHANGE_FLAG], ea[2:0]};
   endfunction

   // ==================================================================
   // Combined interrupt bit and request outputs.
   logic [4:0] other_q;
   logic int_d;
   logic int_q;
   logic dma_d;
   logic dma_q;
   // Lockout and remote levels are left out: they never interrupt.
   always_comb begin
      int_d = (|(flags_d & flag_en(en_a_d, en_b_d))) |
              (|(core.other_a_flags & en_a_d[7:3]));
   end
   // A DMA request is made when so enabled, unless the per-byte interrupt is enabled.
   always_comb begin
      dma_d = (en_b_d[ges_pkg::EB_DMA_OUT] & ~en_a_d[ges_pkg::FL_DO] &
               core.speaker_active & flags_d[ges_pkg::FL_DO]) |
              (en_b_d[ges_pkg::EB_DMA_IN] & ~en_a_d[ges_pkg::FL_DI] &
               core.listener_active & flags_d[ges_pkg::FL_DI]);
   end
   // Registered copies feed the pins and the status read.
   always_ff @(posedge clk) begin
      if (rst) begin
         int_q <= 1'b0;
         dma_q <= 1'b0;
         other_q <= 5'h00;
      end else begin
         int_q <= int_d;
         dma_q <= dma_d;
         other_q <= core.other_a_flags;
      end
   end
   assign irq = int_q;
   assign dma_req = dma_q;

   // ==================================================================
   // Read data, captured on the read strobe.
   logic [7:0] rdata_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= ges_pkg::RST_BYTE;
      end else if (rd_a) begin
         rdata_q <= {other_q, flags_q[ges_pkg::FL_ERR:ges_pkg::FL_DI]};
      end else if (rd_b) begin
         rdata_q <= {int_q, flags_q[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG], lok_q, rem_q,
                     flags_q[ges_pkg::FL_CO], flags_q[ges_pkg::FL_LOCKOUT_CHANGE_FLAG],
                     flags_q[ges_pkg::FL_FAR_CONTROL_CHANGE_FLAG],
                     flags_q[ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG]};
      end else if (host_rd) begin
         rdata_q <= ges_pkg::RST_BYTE;
      end
   end
   assign host_rdata = rdata_q;

   // ==================================================================
   // Checks.
   logic [ges_pkg::NFLAG-1:0] en_now;
   assign en_now = flag_en(en_a_q, en_b_q);

   chk_err_set: assert property (@(posedge clk) disable iff (rst)
      (set_v[ges_pkg::FL_ERR] && !rd_a) |=> flags_q[ges_pkg::FL_ERR])
      else $error("error flag not set on lost byte");

   chk_read_a_clr: assert property (@(posedge clk) disable iff (rst)
      rd_a |=> (flags_q[ges_pkg::FL_ERR:ges_pkg::FL_DI] == 3'h0))
      else $error("first status flags not cleared by read");

   chk_read_b_clr: assert property (@(posedge clk) disable iff (rst)
      rd_b |=> (flags_q[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG:ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG] == 5'h00))
      else $error("second status flags not cleared by read");

   chk_read_defer: assert property (@(posedge clk) disable iff (rst)
      (rd_b && set_v[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG]) |=> ##1 flags_q[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG])
      else $error("event during read was lost");

   chk_do_leave: assert property (@(posedge clk) disable iff (rst)
      (!watch[ges_pkg::WA_DO] && !rd_a && !rise[ges_pkg::WA_DO])
      |=> !flags_q[ges_pkg::FL_DO] || $past(flags_q[ges_pkg::FL_DO], 2))
      else $error("data-out flag held after leaving talk");

   chk_irq_level: assert property (@(posedge clk) disable iff (rst)
      irq == ((|(flags_q & en_now)) | (|(other_q & en_a_q[7:3]))))
      else $error("interrupt output differs from enabled flags");

   chk_dma_cause: assert property (@(posedge clk) disable iff (rst)
      dma_req |-> ((en_b_q[ges_pkg::EB_DMA_OUT] &&
                    flags_q[ges_pkg::FL_DO] && !en_a_q[ges_pkg::FL_DO]) ||
                   (en_b_q[ges_pkg::EB_DMA_IN] &&
                    flags_q[ges_pkg::FL_DI] && !en_a_q[ges_pkg::FL_DI])))
      else $error("DMA request without enabled byte flag");

   chk_svc_request_seen_flag_set: assert property (@(posedge clk) disable iff (rst)
      ($rose(watch[ges_pkg::WA_SRQ_A]) && !rd_b)
      |=> flags_q[ges_pkg::FL_SVC_REQUEST_SEEN_FLAG])
      else $error("service request not flagged");

   chk_remote_bit: assert property (@(posedge clk) disable iff (rst)
      (!rd_b && (core.rl_remote || core.rl_remote_lock)) |=> rem_q)
      else $error("remote bit not shown");

   chk_lok_change: assert property (@(posedge clk) disable iff (rst)
      ($changed(lok_q) && !rd_b) |=> flags_q[ges_pkg::FL_LOCKOUT_CHANGE_FLAG])
      else $error("lockout change not flagged");

   chk_addr_only: assert property (@(posedge clk) disable iff (rst)
      (!flags_q[ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG] && (core.listen_only || core.talk_only)
       && !$past(rd_b))
      |=> !flags_q[ges_pkg::FL_ADDR_ROLE_CHANGE_FLAG])
      else $error("role change flagged in only-mode");

   // A byte accepted in continuous listen must show one cycle later.
   chk_di_set: assert property (@(posedge clk) disable iff (rst)
      (rise[ges_pkg::WA_DI] && !rd_a) |=> flags_q[ges_pkg::FL_DI])
      else $error("data-in flag not set on accept");

   // The command register empty flag follows its condition edge.
   chk_co_set: assert property (@(posedge clk) disable iff (rst)
      (rise[ges_pkg::WA_CO] && !rd_b) |=> flags_q[ges_pkg::FL_CO])
      else $error("command-out flag not set");
endmodule // ges_event_status
`default_nettype wire

// [shared/ges_pkg.sv]
`default_nettype none
// =====================================================================
// Shared constants and types for the event status block.
package ges_pkg;
   // =================================================================
   // Register offsets on the host port.
   localparam logic [8:0] OFS_OUT_BYTE = 9'h111;
   localparam logic [8:0] OFS_STAT_A = 9'h113;
   localparam logic [8:0] OFS_STAT_B = 9'h115;
   // =================================================================
   // Positions of the sticky flags in the internal flag vector.
   localparam int NFLAG = 8;
   localparam int FL_DI = 0;
   localparam int FL_DO = 1;
   localparam int FL_ERR = 2;
   localparam int FL_ADDR_ROLE_CHANGE_FLAG = 3;
   localparam int FL_FAR_CONTROL_CHANGE_FLAG = 4;
   localparam int FL_LOCKOUT_CHANGE_FLAG = 5;
   localparam int FL_CO = 6;
   localparam int FL_SVC_REQUEST_SEEN_FLAG = 7;
   // =================================================================
   // Bit positions in the second enable register.
   localparam int EB_ADDR_ROLE_CHANGE_FLAG = 0;
   localparam int EB_FAR_CONTROL_CHANGE_FLAG = 1;
   localparam int EB_LOCKOUT_CHANGE_FLAG = 2;
   localparam int EB_CO = 3;
   localparam int EB_DMA_IN = 4;
   localparam int EB_DMA_OUT = 5;
   localparam int EB_SVC_REQUEST_SEEN_FLAG = 6;
   // =================================================================
   // Positions in the watched-condition vector of the edge detector.
   localparam int NWATCH = 11;
   localparam int WA_DO = 0;
   localparam int WA_DI = 1;
   localparam int WA_CO = 2;
   localparam int WA_SRQ_A = 3;
   localparam int WA_SRQ_B = 4;
   localparam int WA_LOK = 5;
   localparam int WA_REM = 6;
   localparam int WA_ADDR = 7;
   // =================================================================
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [NFLAG-1:0] RST_FLAGS = 8'h00;
   localparam logic [NWATCH-1:0] RST_WATCH = 11'h000;
   // Protocol core state inputs.
   typedef struct packed {
      logic speaker_active;
      logic listener_active;
      logic ctrl_active;
      logic src_generate;
      logic src_idle;
      logic src_delay_to_idle;
      logic no_listener_send;
      logic accept_data;
      logic cont_listen;
      logic holdoff;
      logic finish_hs;
      logic in_byte_read;
      logic bus_ctrl_owner_flag;
      logic srq;
      logic rqs;
      logic dav;
      logic rl_local_lock;
      logic rl_remote_lock;
      logic rl_remote;
      logic speaker_on_flag;
      logic listener_on_flag;
      logic minor_addr_flag;
      logic listen_only;
      logic talk_only;
      logic [4:0] other_a_flags;
   } ges_core_t;
endpackage
`default_nettype wire

// [src/ges_edge.sv]
`default_nettype none
// =====================================================================
// Rise and change detector for a vector of condition levels.
module ges_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ges_pkg::NWATCH-1:0] level,
   output logic [ges_pkg::NWATCH-1:0] rise,
   output logic [ges_pkg::NWATCH-1:0] chg
);
   logic [ges_pkg::NWATCH-1:0] prev_q;
   // Remember last cycle's levels.
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= ges_pkg::RST_WATCH;
      end else begin
         prev_q <= level;
      end
   end
   // Edges compare against the remembered levels.
   assign rise = level & ~prev_q;
   assign chg = level ^ prev_q;
endmodule // ges_edge
`default_nettype wire

// [src/ges_flag.sv]
`default_nettype none
// =====================================================================
// One sticky flag with read clear and deferral of coincident changes.
module ges_flag (
   input wire logic clk,
   input wire logic rst,
   input wire logic set_ev,
   input wire logic clr_ev,
   input wire logic rd_clr,
   output logic flag_d,
   output logic flag_q
);
   logic pend_set_q;
   logic pend_clr_q;
   logic set_all;
   logic clr_all;
   assign set_all = set_ev | pend_set_q;
   assign clr_all = clr_ev | pend_clr_q;
   // A read clears; otherwise a set beats a clear.
   always_comb begin
      if (rd_clr) begin
         flag_d = 1'b0;
      end else if (set_all) begin
         flag_d = 1'b1;
      end else if (clr_all) begin
         flag_d = 1'b0;
      end else begin
         flag_d = flag_q;
      end
   end
   // Changes seen during a read are held back one cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= 1'b0;
         pend_set_q <= 1'b0;
         pend_clr_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         pend_set_q <= rd_clr & set_all;
         pend_clr_q <= rd_clr & clr_all & ~set_all;
      end
   end
endmodule // ges_flag
`default_nettype wire

// [dv/ges_dma_model.sv]
`default_nettype none
// =====================================================================
// DMA side of the host: answers each data request with an out-byte write.
module ges_dma_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic dma_req,
   input wire logic en,
   input wire logic [3:0] stall,
   output logic wr,
   output logic [8:0] addr,
   output logic [7:0] wdata,
   output int n_xfer
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   // Wait stall cycles of a standing request, then write one byte.
   always_ff @(posedge clk) begin
      if (rst || !en || wr || !dma_req) begin
         wr <= 1'b0;
         cnt_q <= 4'h0;
      end else if (cnt_q == stall) begin
         wr <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // Count finished transfers for the bench.
   always_ff @(posedge clk) begin
      if (rst) begin
         n_xfer <= 0;
      end else if (wr) begin
         n_xfer <= n_xfer + 1;
      end
   end
   // Address is only meaningful while the strobe is up.
   assign addr = wr ? ges_pkg::OFS_OUT_BYTE : ~ges_pkg::OFS_OUT_BYTE;
   assign wdata = n_xfer[7:0];
endmodule // ges_dma_model
`default_nettype wire

// [dv/gpib_event_status_logic_tb.sv]
`default_nettype none
// =====================================================================
// Self-checking bench for the event status block.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
   end end
module gpib_event_status_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [8:0] SA = ges_pkg::OFS_STAT_A;
   localparam logic [8:0] SB = ges_pkg::OFS_STAT_B;
   localparam logic [8:0] OB = ges_pkg::OFS_OUT_BYTE;
   logic clk, rst, b_rd, b_wr, m_wr, irq, dma_req, m_en;
   logic [3:0] stall;
   logic [8:0] b_addr, m_addr;
   logic [7:0] b_wdata, m_wdata, rdata, v;
   ges_pkg::ges_core_t core_s, c;
   int n_xfer;
   int n_mismatch = 0;
   int n_checks = 0;
   // =====================================================================
   // Clock, design and DMA partner sharing the host port.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ges_event_status DUT (
      .clk(clk), .rst(rst),
      .host_addr(m_wr ? m_addr : b_addr),
      .host_rd(b_rd),
      .host_wr(b_wr | m_wr),
      .host_wdata(m_wr ? m_wdata : b_wdata),
      .host_rdata(rdata),
      .core(core_s),
      .irq(irq), .dma_req(dma_req)
   );
   ges_dma_model dma (
      .clk(clk), .rst(rst), .dma_req(dma_req), .en(m_en),
      .stall(stall), .wr(m_wr), .addr(m_addr), .wdata(m_wdata),
      .n_xfer(n_xfer)
   );
   // =====================================================================
   // Host port and core tasks.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      b_addr <= a;
      b_wdata <= d;
      b_wr <= 1'b1;
      @(posedge clk);
      b_wr <= 1'b0;
   endtask
   // Read, launching a core change on the same edge as the strobe.
   task automatic rdc(input logic [8:0] a, input ges_pkg::ges_core_t n,
                      output logic [7:0] d);
      @(posedge clk);
      b_addr <= a;
      b_rd <= 1'b1;
      core_s <= n;
      @(posedge clk);
      b_rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic xrd(input logic [8:0] a, input logic [7:0] e,
                      input string nm);
      rdc(a, core_s, v);
      `CHK(nm, e, v)
   endtask
   task automatic setc(input ges_pkg::ges_core_t n);
      @(posedge clk);
      core_s <= n;
      tick(3);
   endtask
   task automatic pulse(input ges_pkg::ges_core_t n);
      ges_pkg::ges_core_t o;
      o = core_s;
      @(posedge clk);
      core_s <= n;
      @(posedge clk);
      core_s <= o;
      tick(2);
   endtask
   // Let the partner serve one request within a bounded wait.
   task automatic xfer(input int n);
      for (int i = 0; i < 40 && n_xfer != n; i++) @(posedge clk);
      tick(3);
      `CHK("xfer", n, n_xfer)
      `CHK("dma_done", 1'b0, dma_req)
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #400us;
      n_mismatch++;
      close_out();
   end
   // =====================================================================
   // Test sequence.
   initial begin
      rst = 1'b1;
      b_rd = 1'b0;
      b_wr = 1'b0;
      b_addr = 9'h000;
      b_wdata = 8'h00;
      m_en = 1'b0;
      stall = 4'h9;
      core_s = '0;
      tick(3);
      rst <= 1'b0;
      xrd(SA, 8'h00, "a_rst");
      xrd(SB, 8'h00, "b_rst");
      `CHK("irq_rst", 1'b0, irq)
      $display("test reset done");
      wr(SA, 8'h02);
      c = core_s;
      c.speaker_active = 1'b1;
      c.src_generate = 1'b1;
      setc(c);
      `CHK("irq_out", 1'b1, irq)
      xrd(SB, 8'h80, "int_out");
      xrd(SA, 8'h02, "out_set");
      xrd(SA, 8'h00, "out_rc");
      `CHK("irq_rc", 1'b0, irq)
      c.src_generate = 1'b0;
      setc(c);
      c.src_generate = 1'b1;
      setc(c);
      wr(OB, 8'h5A);
      tick(2);
      xrd(SA, 8'h00, "out_wr");
      c.src_generate = 1'b0;
      setc(c);
      c.src_generate = 1'b1;
      setc(c);
      c.speaker_active = 1'b0;
      setc(c);
      xrd(SA, 8'h00, "out_leave");
      $display("test data out done");
      wr(SA, 8'h00);
      wr(SB, 8'h20);
      m_en <= 1'b1;
      c.speaker_active = 1'b1;
      setc(c);
      `CHK("dma_out", 1'b1, dma_req)
      `CHK("irq_dma", 1'b0, irq)
      xfer(1);
      stall <= 4'h4;
      c.src_generate = 1'b0;
      setc(c);
      c.src_generate = 1'b1;
      setc(c);
      xfer(2);
      m_en <= 1'b0;
      $display("test dma out done");
      c = '0;
      c.listener_active = 1'b1;
      c.accept_data = 1'b1;
      c.cont_listen = 1'b1;
      wr(SB, 8'h10);
      setc(c);
      `CHK("dma_in", 1'b1, dma_req)
      xrd(SA, 8'h01, "in_set");
      `CHK("dma_in_rc", 1'b0, dma_req)
      c.accept_data = 1'b0;
      setc(c);
      c.accept_data = 1'b1;
      setc(c);
      c.in_byte_read = 1'b1;
      pulse(c);
      xrd(SA, 8'h00, "in_rd");
      c.in_byte_read = 1'b0;
      c.accept_data = 1'b0;
      setc(c);
      c.accept_data = 1'b1;
      c.holdoff = 1'b1;
      setc(c);
      c.finish_hs = 1'b1;
      pulse(c);
      xrd(SA, 8'h00, "in_fin");
      $display("test data in done");
      c = '0;
      setc(c);
      c.no_listener_send = 1'b1;
      pulse(c);
      xrd(SA, 8'h04, "lost_send");
      xrd(SA, 8'h00, "lost_rc");
      c.no_listener_send = 1'b0;
      c.src_idle = 1'b1;
      setc(c);
      wr(OB, 8'hA5);
      tick(2);
      xrd(SA, 8'h04, "lost_idle");
      $display("test lost byte done");
      wr(SB, 8'h4F);
      c = '0;
      c.bus_ctrl_owner_flag = 1'b1;
      c.srq = 1'b1;
      setc(c);
      `CHK("irq_srq", 1'b1, irq)
      xrd(SB, 8'hC1, "srq_set");
      xrd(SB, 8'h00, "srq_rc");
      c.rl_remote = 1'b1;
      setc(c);
      xrd(SB, 8'h92, "far_set");
      c.rl_local_lock = 1'b1;
      setc(c);
      xrd(SB, 8'hB4, "lock_set");
      xrd(SB, 8'h30, "lock_rc");
      `CHK("irq_lock", 1'b0, irq)
      c.ctrl_active = 1'b1;
      c.src_generate = 1'b1;
      setc(c);
      xrd(SB, 8'hB8, "cmd_set");
      c.src_generate = 1'b0;
      setc(c);
      c.src_generate = 1'b1;
      setc(c);
      c.ctrl_active = 1'b0;
      setc(c);
      xrd(SB, 8'h30, "cmd_leave");
      c.listen_only = 1'b1;
      c.speaker_on_flag = 1'b1;
      setc(c);
      xrd(SB, 8'h30, "role_only");
      c.listen_only = 1'b0;
      setc(c);
      c.speaker_on_flag = 1'b0;
      setc(c);
      xrd(SB, 8'hB1, "role_set");
      wr(SB, 8'h00);
      c.minor_addr_flag = 1'b1;
      setc(c);
      xrd(SB, 8'h31, "mask_free");
      wr(SB, 8'h01);
      c.minor_addr_flag = 1'b0;
      rdc(SB, c, v);
      `CHK("defer_snap", 8'h30, v)
      tick(3);
      `CHK("irq_defer", 1'b1, irq)
      xrd(SB, 8'hB1, "defer_set");
      $display("test status b done");
      close_out();
   end
endmodule // gpib_event_status_logic_tb
`default_nettype wire
